/* File: rtl/tcc_timer.sv */
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_timer
    import tcc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic own_filtered_input,
    output logic channel_output,
    output logic channel_output_n,
    output logic update_event,
    output logic irq
);
    tcc_state_s s_q;
    tcc_state_s s_d;

    logic [15:0] wd16;
    logic w_ctl, w_cnt, w_psc, w_car, w_cv, w_swev, w_stat, w_mask;
    logic cen, chen, pol, npol, csen;
    tcc_ms_e ms;
    logic tick, ovf, upd, cap_edge, cmp_hit, cap_ok, in_rise, in_fall;
    logic [2:0] ev;

    assign wd16 = wdata[15:0];
    assign w_ctl = wr && addr == `TCC_OFF_CTL;
    assign w_cnt = wr && addr == `TCC_OFF_CNT;
    assign w_psc = wr && addr == `TCC_OFF_PSC;
    assign w_car = wr && addr == `TCC_OFF_CAR;
    assign w_cv = wr && addr == `TCC_OFF_CV;
    assign w_swev = wr && addr == `TCC_OFF_SWEV && wdata[`TCC_SWEV_UPG];
    assign w_stat = wr && addr == `TCC_OFF_STAT;
    assign w_mask = wr && addr == `TCC_OFF_MASK;

    assign cen = s_q.ctl[`TCC_CTL_CEN];
    assign chen = s_q.ctl[`TCC_CTL_EN];
    assign pol = s_q.ctl[`TCC_CTL_P];
    assign npol = s_q.ctl[`TCC_CTL_NP];
    assign csen = s_q.ctl[`TCC_CTL_CSEN];
    assign ms = tcc_ms_e'(s_q.ctl[`TCC_CTL_MS_HI:`TCC_CTL_MS_LO]);

    // Counter clock enable: one pulse every divisor+1 kernel cycles
    assign tick = cen && s_q.pcnt == s_q.psc_sh;
    assign ovf = tick && s_q.cnt == s_q.car;
    assign upd = ovf || w_swev;

    assign in_rise = own_filtered_input && !s_q.in_prev;
    assign in_fall = !own_filtered_input && s_q.in_prev;
    always_comb begin
        case ({npol, pol})
            2'b00: cap_edge = in_rise;
            2'b01: cap_edge = in_fall;
            2'b11: cap_edge = in_rise || in_fall;
            default: cap_edge = 1'b0;
        endcase
    end
    assign cap_ok = chen && ms == TCC_MS_IN && cap_edge;
    assign cmp_hit = tick && ms == TCC_MS_OUT && s_q.cnt == s_q.cv;
    assign ev = {cmp_hit, cap_ok, upd};

    always_comb begin
        s_d = s_q;
        s_d.in_prev = own_filtered_input;
        if (upd) begin
            s_d.psc_sh = s_q.prescaler_divisor;
            s_d.pcnt = `TCC_RST16;
        end else if (cen) begin
            s_d.pcnt = tick ? `TCC_RST16 : s_q.pcnt + 16'h0001;
        end
        if (upd) begin
            s_d.cnt = `TCC_RST16;
        end else if (tick) begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
        if (w_cnt) begin
            s_d.cnt = wd16;
        end
        if (w_psc) begin
            s_d.prescaler_divisor = wd16;
        end
        if (w_car) begin
            s_d.car = wd16;
        end
        if (w_ctl) begin
            s_d.ctl[`TCC_CTL_EN] = wdata[`TCC_CTL_EN];
            s_d.ctl[`TCC_CTL_P] = wdata[`TCC_CTL_P];
            s_d.ctl[`TCC_CTL_NP] = wdata[`TCC_CTL_NP];
            s_d.ctl[`TCC_CTL_CSEN] = wdata[`TCC_CTL_CSEN];
            s_d.ctl[`TCC_CTL_CEN] = wdata[`TCC_CTL_CEN];
            // Mode select may change only while the channel is off
            if (!chen) begin
                s_d.ctl[`TCC_CTL_MS_HI:`TCC_CTL_MS_LO] =
                    wdata[`TCC_CTL_MS_HI:`TCC_CTL_MS_LO];
            end
        end
        // Preload register is written only in output mode
        if (w_cv && ms == TCC_MS_OUT) begin
            s_d.cv_sh = wd16;
            if (!csen) begin
                s_d.cv = wd16;
            end
        end
        if (upd && csen && ms == TCC_MS_OUT) begin
            s_d.cv = s_q.cv_sh;
        end
        if (cap_ok) begin
            s_d.cv = s_q.cnt;
        end
        // Reference level: high while count is below compare value in output mode, low in other modes
        if (ms == TCC_MS_OUT) begin
            s_d.out_lvl = s_d.cnt < s_d.cv;
        end else begin
            s_d.out_lvl = 1'b0;
        end
        if (w_mask) begin
            s_d.mask = wdata[`TCC_ST_W-1:0];
        end
        if (w_stat) begin
            s_d.stat = s_q.stat & ~wdata[`TCC_ST_W-1:0];
        end
        s_d.stat = s_d.stat | ev;
        s_d.rdata = 32'h00000000;
        if (rd) begin
            case (addr)
                `TCC_OFF_CTL: s_d.rdata = {24'h000000, s_q.ctl & 8'hFB};
                `TCC_OFF_CNT: s_d.rdata = {16'h0000, s_q.cnt};
                `TCC_OFF_PSC: s_d.rdata = {16'h0000, s_q.prescaler_divisor};
                `TCC_OFF_CAR: s_d.rdata = {16'h0000, s_q.car};
                `TCC_OFF_CV: s_d.rdata = {16'h0000, s_q.cv};
                `TCC_OFF_STAT: s_d.rdata = {29'h0000000, s_q.stat};
                `TCC_OFF_MASK: s_d.rdata = {29'h0000000, s_q.mask};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    // Idle at inactive level when disabled
    assign channel_output = (chen && s_q.out_lvl) ^ pol;
    assign channel_output_n = (chen && s_q.out_lvl) ^ npol;
    assign update_event = upd;
    assign irq = |(s_q.stat & s_q.mask);

    a_psc_write: assert property (@(posedge mclk) disable iff (rst)
        w_psc |=> s_q.prescaler_divisor == $past(wd16))
        else $error("prescaler write lost");

    a_psc_shadow: assert property (@(posedge mclk) disable iff (rst)
        !$past(upd) && !$past(rst) |-> $stable(s_q.psc_sh))
        else $error("prescaler shadow changed without update");

    a_psc_deferred: assert property (@(posedge mclk) disable iff (rst)
        w_psc && !upd |=> $stable(s_q.psc_sh))
        else $error("prescaler write reached shadow early");

    a_psc_load: assert property (@(posedge mclk) disable iff (rst)
        upd |=> s_q.psc_sh == $past(s_q.prescaler_divisor))
        else $error("prescaler shadow not loaded on update");

    a_update_source: assert property (@(posedge mclk) disable iff (rst)
        update_event |-> ovf || w_swev)
        else $error("update event without a cause");

    a_tick_gated: assert property (@(posedge mclk) disable iff (rst)
        !cen |-> !tick)
        else $error("counter tick while counter stopped");

    a_tick_spacing: assert property (@(posedge mclk) disable iff (rst)
        tick && !upd && cen ##1 (cen && !upd && !w_cnt) [*2]
            |-> !$past(tick) || s_q.psc_sh == 16'h0000)
        else $error("counter tick spacing wrong");

    a_pcnt_step: assert property (@(posedge mclk) disable iff (rst)
        cen && !upd && !tick |=> s_q.pcnt == $past(s_q.pcnt) + 16'h0001)
        else $error("prescaler counter did not advance");

    a_pcnt_wrap: assert property (@(posedge mclk) disable iff (rst)
        tick && !upd |=> s_q.pcnt == 16'h0000)
        else $error("prescaler counter did not wrap");

    a_pcnt_hold: assert property (@(posedge mclk) disable iff (rst)
        !cen && !upd |=> $stable(s_q.pcnt))
        else $error("prescaler counter moved while stopped");

    a_cnt_write: assert property (@(posedge mclk) disable iff (rst)
        w_cnt |=> s_q.cnt == $past(wd16))
        else $error("counter write lost");

    a_cnt_step: assert property (@(posedge mclk) disable iff (rst)
        tick && !upd && !w_cnt |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
        else $error("counter did not step on tick");

    a_cnt_hold: assert property (@(posedge mclk) disable iff (rst)
        !tick && !upd && !w_cnt |=> $stable(s_q.cnt))
        else $error("counter moved without tick");

    a_cnt_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == `TCC_OFF_CNT |=> rdata == {16'h0000, $past(s_q.cnt)})
        else $error("counter read wrong");

    a_car_write: assert property (@(posedge mclk) disable iff (rst)
        w_car |=> s_q.car == $past(wd16))
        else $error("reload value write lost");

    a_ovf_limit: assert property (@(posedge mclk) disable iff (rst)
        ovf |-> s_q.cnt == s_q.car)
        else $error("overflow away from reload value");

    a_counter_reload: assert property (@(posedge mclk) disable iff (rst)
        ovf && !w_cnt |=> s_q.cnt == 16'h0000)
        else $error("counter did not reload");

    a_swev_clear: assert property (@(posedge mclk) disable iff (rst)
        w_swev |=> s_q.cnt == 16'h0000 && s_q.pcnt == 16'h0000)
        else $error("software update did not clear counters");

    a_capture_latch: assert property (@(posedge mclk) disable iff (rst)
        cap_ok |=> s_q.cv == $past(s_q.cnt) && s_q.stat[`TCC_ST_CAP])
        else $error("capture value not latched");

    a_cv_readonly: assert property (@(posedge mclk) disable iff (rst)
        w_cv && ms == TCC_MS_IN && !cap_ok |=> $stable(s_q.cv))
        else $error("capture value written by software");

    a_cv_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == `TCC_OFF_CV |=> rdata == {16'h0000, $past(s_q.cv)})
        else $error("capture compare read wrong");

    a_cap_disabled: assert property (@(posedge mclk) disable iff (rst)
        !chen || ms != TCC_MS_IN |-> !cap_ok)
        else $error("capture while channel off");

    a_reserved_pol: assert property (@(posedge mclk) disable iff (rst)
        npol && !pol |-> !cap_ok)
        else $error("capture with reserved polarity");

    a_rise_capture: assert property (@(posedge mclk) disable iff (rst)
        chen && ms == TCC_MS_IN && !npol && !pol && in_rise |-> cap_ok)
        else $error("rising edge not captured");

    a_fall_ignored: assert property (@(posedge mclk) disable iff (rst)
        !npol && !pol && in_fall |-> !cap_ok)
        else $error("falling edge captured in rising mode");

    a_fall_capture: assert property (@(posedge mclk) disable iff (rst)
        chen && ms == TCC_MS_IN && !npol && pol && in_fall |-> cap_ok)
        else $error("falling edge not captured");

    a_rise_ignored: assert property (@(posedge mclk) disable iff (rst)
        !npol && pol && in_rise |-> !cap_ok)
        else $error("rising edge captured in falling mode");

    a_both_edges: assert property (@(posedge mclk) disable iff (rst)
        chen && ms == TCC_MS_IN && npol && pol && (in_rise || in_fall) |-> cap_ok)
        else $error("edge missed in both edge mode");

    a_out_no_capture: assert property (@(posedge mclk) disable iff (rst)
        ms == TCC_MS_OUT |-> !cap_ok)
        else $error("capture in output mode");

    a_in_no_compare: assert property (@(posedge mclk) disable iff (rst)
        ms != TCC_MS_OUT |-> !cmp_hit)
        else $error("compare match outside output mode");

    a_mode_locked: assert property (@(posedge mclk) disable iff (rst)
        chen |=> $stable(ms))
        else $error("mode select changed while channel on");

    a_mode_write: assert property (@(posedge mclk) disable iff (rst)
        w_ctl && !chen |=> s_q.ctl[`TCC_CTL_MS_HI:`TCC_CTL_MS_LO] ==
            $past(wdata[`TCC_CTL_MS_HI:`TCC_CTL_MS_LO]))
        else $error("mode select write lost");

    a_ref_idle: assert property (@(posedge mclk) disable iff (rst)
        ms != TCC_MS_OUT |=> !s_q.out_lvl)
        else $error("reference active outside output mode");

    a_ref_level: assert property (@(posedge mclk) disable iff (rst)
        ms == TCC_MS_OUT |=> s_q.out_lvl == (s_q.cnt < s_q.cv))
        else $error("reference level does not follow compare");

    a_direct_cv: assert property (@(posedge mclk) disable iff (rst)
        w_cv && ms == TCC_MS_OUT && !csen && !cap_ok |=> s_q.cv == $past(wd16))
        else $error("direct compare write lost");

    a_shadow_write: assert property (@(posedge mclk) disable iff (rst)
        w_cv && ms == TCC_MS_OUT |=> s_q.cv_sh == $past(wd16))
        else $error("compare preload write lost");

    a_shadow_hold: assert property (@(posedge mclk) disable iff (rst)
        w_cv && ms == TCC_MS_OUT && csen && !upd |=> $stable(s_q.cv))
        else $error("shadowed compare changed before update");

    a_shadow_load: assert property (@(posedge mclk) disable iff (rst)
        upd && csen && ms == TCC_MS_OUT |=> s_q.cv == $past(s_q.cv_sh))
        else $error("compare shadow not loaded on update");

    a_compare_flag: assert property (@(posedge mclk) disable iff (rst)
        cmp_hit |=> s_q.stat[`TCC_ST_CMP])
        else $error("compare match flag not set");

    a_out_pol: assert property (@(posedge mclk) disable iff (rst)
        !chen |-> channel_output == pol && channel_output_n == npol)
        else $error("disabled output not at inactive level");

    a_main_active: assert property (@(posedge mclk) disable iff (rst)
        chen && s_q.out_lvl |-> channel_output == !pol)
        else $error("main output not at active level");

    a_compl_active: assert property (@(posedge mclk) disable iff (rst)
        chen && s_q.out_lvl |-> channel_output_n == !npol)
        else $error("complementary output not at active level");

    a_reset_state: assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> s_q == '0)
        else $error("state not cleared by reset");
endmodule : tcc_timer

/* File: rtl/tcc_defs.svh */
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
// Register byte offsets
`define TCC_OFF_CTL 8'h20
`define TCC_OFF_CNT 8'h24
`define TCC_OFF_PSC 8'h28
`define TCC_OFF_CAR 8'h2C
`define TCC_OFF_CV 8'h34
`define TCC_OFF_SWEV 8'h38
`define TCC_OFF_STAT 8'h3C
`define TCC_OFF_MASK 8'h40
// Control register fields
`define TCC_CTL_EN 0
`define TCC_CTL_P 1
`define TCC_CTL_NP 3
`define TCC_CTL_MS_LO 4
`define TCC_CTL_MS_HI 5
`define TCC_CTL_CSEN 6
`define TCC_CTL_CEN 7
// Status and mask fields
`define TCC_ST_UPD 0
`define TCC_ST_CAP 1
`define TCC_ST_CMP 2
`define TCC_ST_W 3
// Software event register bit
`define TCC_SWEV_UPG 0
// Reset value of every register
`define TCC_RST16 16'h0000
`endif

/* File: rtl/tcc_pkg.sv */
package tcc_pkg;
    typedef enum logic [1:0] {
        TCC_MS_OUT = 2'h0,
        TCC_MS_IN = 2'h1,
        TCC_MS_R2 = 2'h2,
        TCC_MS_R3 = 2'h3
    } tcc_ms_e;
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] prescaler_divisor;
        logic [15:0] psc_sh;
        logic [15:0] pcnt;
        logic [15:0] car;
        logic [15:0] cv;
        logic [15:0] cv_sh;
        logic [7:0] ctl;
        logic [2:0] stat;
        logic [2:0] mask;
        logic in_prev;
        logic out_lvl;
        logic [31:0] rdata;
    } tcc_state_s;
endpackage : tcc_pkg

/* File: verif/tcc_sig_src.sv */
`timescale 1ns/1ps
module tcc_sig_src (
    input wire logic mclk,
    output logic sig
);
    initial sig = 1'b0;
    // Moves just after an edge, then holds long enough for a capture to land
    task automatic drive(input logic v);
        @(posedge mclk);
        sig <= v;
        repeat (3) @(posedge mclk);
    endtask : drive
endmodule : tcc_sig_src

/* File: verif/tcc_timer_test.sv */
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_timer_test;
    logic mclk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic sig, ch_o, ch_n, upd, irq;
    logic [15:0] k;
    logic [7:0] offs[5] = '{`TCC_OFF_CTL, `TCC_OFF_CNT, `TCC_OFF_PSC, `TCC_OFF_CAR, `TCC_OFF_CV};
    logic [31:0] pm[3] = '{32'h0, 32'h2, 32'hA};
    logic [31:0] exp_q[$], gap_q[$];
    int err_count = 0, comparisons = 0, seed = 26976, cyc = 0, last = 0;
    always #5 mclk = ~mclk;
    tcc_timer u_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .own_filtered_input(sig), .channel_output(ch_o),
        .channel_output_n(ch_n), .update_event(upd), .irq(irq));
    tcc_sig_src u_src (.mclk(mclk), .sig(sig));
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(negedge mclk);
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge mclk);
        rd <= 1'b0;
    endtask : rd_chk
    // Read data stand only in the cycle after the strobe
    always @(posedge mclk) begin
        if (rd_d)
            check("rdata", rdata, exp_q.pop_front());
        rd_d <= rd;
    end
    // Spacing of update pulses against the noted spans
    always @(posedge mclk) begin
        if (upd) begin
            if (gap_q.size() > 0)
                check("update gap", 32'(cyc - last), gap_q.pop_front());
            last = cyc;
        end
        cyc++;
    end
    initial begin
        #100000;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        foreach (offs[i]) rd_chk(offs[i], 32'h0);
        rd_chk(8'h10, 32'h0);
        for (int i = 1; i < 4; i++) begin
            k = 16'($random(seed));
            wr_reg(offs[i], {16'h0, k});
            rd_chk(offs[i], {16'h0, k});
        end
        $display("test registers done");
        wr_reg(`TCC_OFF_CNT, 32'h0);
        wr_reg(`TCC_OFF_CV, 32'h5);
        for (int i = 0; i < 8; i++) begin
            wr_reg(`TCC_OFF_CTL, {28'h0, i[2], 1'b0, i[1], i[0]});
            check("main out", 32'(ch_o), 32'(i[0] ^ i[1]));
            check("compl out", 32'(ch_n), 32'(i[0] ^ i[2]));
        end
        $display("test polarity done");
        wr_reg(`TCC_OFF_CTL, 32'h41);
        wr_reg(`TCC_OFF_CNT, 32'h6);
        wr_reg(`TCC_OFF_CV, 32'h9);
        check("shadowed cmp", 32'(ch_o), 32'h0);
        wr_reg(`TCC_OFF_SWEV, 32'h1);
        wr_reg(`TCC_OFF_CNT, 32'h6);
        check("loaded cmp", 32'(ch_o), 32'h1);
        wr_reg(`TCC_OFF_CTL, 32'h01);
        wr_reg(`TCC_OFF_CV, 32'h4);
        check("direct cmp", 32'(ch_o), 32'h0);
        $display("test shadow done");
        wr_reg(`TCC_OFF_CAR, 32'h2);
        wr_reg(`TCC_OFF_PSC, 32'h1);
        wr_reg(`TCC_OFF_SWEV, 32'h1);
        wr_reg(`TCC_OFF_CTL, 32'h80);
        @(posedge mclk iff upd);
        wr_reg(`TCC_OFF_PSC, 32'h3);
        gap_q = '{32'h6, 32'hC};
        repeat (30) @(posedge mclk);
        wr_reg(`TCC_OFF_CTL, 32'h0);
        $display("test prescaler done");
        wr_reg(`TCC_OFF_CV, 32'h1);
        wr_reg(`TCC_OFF_MASK, 32'h4);
        wr_reg(`TCC_OFF_STAT, 32'h7);
        wr_reg(`TCC_OFF_CTL, 32'h80);
        repeat (16) @(posedge mclk);
        wr_reg(`TCC_OFF_CTL, 32'h0);
        check("compare irq", 32'(irq), 32'h1);
        rd_chk(`TCC_OFF_STAT, 32'h5);
        $display("test compare done");
        wr_reg(`TCC_OFF_MASK, 32'h2);
        for (int m = 0; m < 3; m++) begin
            k = 16'($random(seed));
            wr_reg(`TCC_OFF_CTL, 32'h10 | pm[m]);
            wr_reg(`TCC_OFF_CTL, 32'h11 | pm[m]);
            wr_reg(`TCC_OFF_CNT, {16'h0, k});
            wr_reg(`TCC_OFF_STAT, 32'h7);
            u_src.drive(1'b1);
            check("irq rise", 32'(irq), 32'(m != 1));
            wr_reg(`TCC_OFF_STAT, 32'h7);
            check("irq clear", 32'(irq), 32'h0);
            u_src.drive(1'b0);
            check("irq fall", 32'(irq), 32'(m != 0));
            wr_reg(`TCC_OFF_CV, {16'h0, ~k});
            rd_chk(`TCC_OFF_CV, {16'h0, k});
        end
        wr_reg(`TCC_OFF_CTL, 32'h1A);
        wr_reg(`TCC_OFF_STAT, 32'h7);
        u_src.drive(1'b1);
        check("irq disabled", 32'(irq), 32'h0);
        $display("test capture done");
        repeat (3) @(posedge mclk);
        finish_test();
    end
endmodule : tcc_timer_test
